// ==== hw/rbps_defs.svh ====
/*
  Register offsets, field positions, reset values and fixed codes of the
  reading buffer with early capture.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef RBPS_DEFS_SVH
`define RBPS_DEFS_SVH

// byte offsets on the register bus
`define RBPS_OFF_CTRL     8'h00
`define RBPS_OFF_SIZE     8'h04
`define RBPS_OFF_MCOUNT   8'h08
`define RBPS_OFF_PCT      8'h0C
`define RBPS_OFF_PRECNT   8'h10
`define RBPS_OFF_FILLED   8'h14
`define RBPS_OFF_STATUS   8'h18
`define RBPS_OFF_MASK     8'h1C
`define RBPS_OFF_ERRCODE  8'h20
`define RBPS_OFF_RDADDR   8'h24
`define RBPS_OFF_RDDATA   8'h28

// control register fields
`define RBPS_CTRL_AUTO    0
`define RBPS_CTRL_EARLY   1
`define RBPS_CTRL_START   2
`define RBPS_CTRL_ABORT   3
`define RBPS_CTRL_ST_LO   4
`define RBPS_CTRL_ST_HI   6

// measurement count register: infinite flag
`define RBPS_MCOUNT_INF   31

// status and mask bits
`define RBPS_ST_CLAMP     0
`define RBPS_ST_AUTO_REF  1
`define RBPS_ST_PARAM     2
`define RBPS_ST_FULL      3
`define RBPS_ST_TRIG      4
`define RBPS_ST_W         5

// reset values, and the 100 percent limit of the early share
`define RBPS_RST_SIZE     32'h0000_0064
`define RBPS_RST_PCT      7'h32
`define RBPS_RST_PRECNT   32'h0000_0032
`define RBPS_RST_MCOUNT   31'h0000_0001
`define RBPS_PCT_FULL     7'h64

// error codes left in the error code register
`define RBPS_ERR_CLAMP    16'h013A
`define RBPS_ERR_AUTO_INF 16'h0101
`define RBPS_ERR_PARAM    16'h0102

`endif

// ==== hw/rbps_pkg.sv ====
/*
  Types shared by the reading buffer files.
  Assumes rbps_defs.svh is on the include path.
*/
package rbps_pkg;
  `include "rbps_defs.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FILL = 3'b001,
    ST_PRE  = 3'b010,
    ST_POST = 3'b011,
    ST_DONE = 3'b100
  } rbps_state_e;

  typedef logic [15:0] rbps_err_t;
endpackage

// ==== hw/rbps_mem_if.sv ====
/*
  Carrier between the buffer control and its reading store.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface rbps_mem_if #(
  parameter int AW = 10,
  parameter int DW = 32
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl  (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== hw/rbps_store.sv ====
/*
  Reading store: one write port, one registered read port.
  Assumes the control side keeps write addresses below DEPTH.
*/
`timescale 1ns/1ps
module rbps_store #(
  parameter int AW    = 10,
  parameter int DW    = 32,
  parameter int DEPTH = 1024
)(
  input wire logic clk_sys,
  rbps_mem_if.store mem
);
  logic [DW-1:0] cells [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW) || DW < 1) begin : g_chk
    $error("rbps_store: DEPTH must be 1..2**AW and DW at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (mem.we) begin
      cells[mem.waddr] <= mem.wdata;
    end
    // out-of-range read addresses return zero rather than aliasing
    if (32'(mem.raddr) < DEPTH) begin
      mem.rdata <= cells[mem.raddr];
    end else begin
      mem.rdata <= '0;
    end
  end
endmodule

// ==== hw/rbps_top.sv ====
/*
  Reading buffer with programmable size, self-sizing from the measurement
  count, a filled-count query and an early-capture split of the buffer.
  Assumes a classic Wishbone master on clk_sys, readings offered as a
  valid-qualified word stream and a one-cycle trigger event pulse, all
  synchronous to clk_sys.
*/
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - size accepts 1 to maximum capacity; 100 readings after reset
// - buffer counts as full when the write position reaches programmed size
// - self-sizing makes size follow the measurement count on every change to a nonzero, finite count
// - self-sized count above capacity clamps size to maximum, error 314
// - turning self-sizing off keeps the size; only size writes change it
// - an explicit size write sets the size and turns self-sizing off
// - enabling self-sizing with an infinite count errors and is ignored
// - the number of readings currently held can be read back
// - early share is 0 to 100 percent, 50 after reset, readable
// - early store writes continuously; after trigger only the late portion
// - early store stops once the last late-portion location is written
// - self-sizing state can be read back
// - early count above the size errors and keeps the old setting
module rbps_top import rbps_pkg::*; #(
  parameter int MAX_BUFFER_SIZE_COMMAND = 1024,
  parameter int DATA_W     = 32
)(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  input  wire logic              rdg_valid,
  input  wire logic [DATA_W-1:0] rdg_data,
  input  wire logic              trig_evt,
  output      logic              irq,
  output      logic              storing,
  output      logic              buf_full
);
  localparam int SZ_W = $clog2(MAX_BUFFER_SIZE_COMMAND + 1);
  localparam int AW   = $clog2(MAX_BUFFER_SIZE_COMMAND);
  localparam logic [31:0] MAX32 = 32'(MAX_BUFFER_SIZE_COMMAND);
  localparam logic [30:0] MAX31 = 31'(MAX_BUFFER_SIZE_COMMAND);

  if (MAX_BUFFER_SIZE_COMMAND < 100 || DATA_W < 1 || DATA_W > 32) begin : g_chk
    $error("rbps_top: MAX_BUFFER_SIZE_COMMAND must be >= 100 and DATA_W 1..32");
  end

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdat;
    logic                  auto_en;
    logic                  early_mode;
    logic [SZ_W-1:0]       size;
    logic [30:0]           mcount;
    logic                  minf;
    logic [6:0]            pct;
    logic                  by_count;
    logic [SZ_W-1:0]       precnt;
    rbps_state_e           st;
    logic [SZ_W-1:0]       wptr;
    logic [SZ_W-1:0]       filled;
    logic [`RBPS_ST_W-1:0] status;
    logic [`RBPS_ST_W-1:0] mask;
    rbps_err_t             errcode;
    logic [AW-1:0]         raddr;
    logic                  irq;
    logic                  busy;
    logic                  full;
  } rbps_regs_s;

  rbps_regs_s s_r;
  rbps_regs_s s_nxt;

  rbps_mem_if #(.AW(AW), .DW(DATA_W)) mem ();

  rbps_store #(.AW(AW), .DW(DATA_W), .DEPTH(MAX_BUFFER_SIZE_COMMAND)) u_store (
    .clk_sys (clk_sys),
    .mem     (mem)
  );

  logic                  req;
  logic                  wr_req;
  logic [31:0]           bmask;
  logic [31:0]           rdmux;
  logic [31:0]           wv;
  logic [SZ_W+6:0]       prod;
  logic [SZ_W-1:0]       rsv;
  logic                  pre_wr;

  // requests are taken only while ack is low, so each cycle is served once
  assign req    = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr_req = req && wb_we_i;
  assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // reserved early-capture locations
  always_comb begin
    prod = s_r.size * s_r.pct;
    if (s_r.by_count) begin
      rsv = (s_r.precnt > s_r.size) ? s_r.size : s_r.precnt;
    end else begin
      rsv = SZ_W'(prod / (SZ_W + 7)'(`RBPS_PCT_FULL));
    end
  end

  assign pre_wr = (s_r.st == ST_PRE) && (rsv != '0);

  // storage writes follow the current state; the address is the write pointer
  assign mem.we    = rdg_valid && ((s_r.st == ST_FILL) || (s_r.st == ST_POST) || pre_wr);
  assign mem.waddr = s_r.wptr[AW-1:0];
  assign mem.wdata = rdg_data;
  assign mem.raddr = s_r.raddr;

  // read view of every register; also the old value for byte-lane merges
  always_comb begin
    rdmux = '0;
    unique case ({wb_adr_i[7:2], 2'b00})
      `RBPS_OFF_CTRL: begin
        rdmux[`RBPS_CTRL_AUTO]  = s_r.auto_en;
        rdmux[`RBPS_CTRL_EARLY] = s_r.early_mode;
        rdmux[`RBPS_CTRL_ST_HI:`RBPS_CTRL_ST_LO] = s_r.st;
      end
      `RBPS_OFF_SIZE:    rdmux = 32'(s_r.size);
      `RBPS_OFF_MCOUNT:  rdmux = {s_r.minf, s_r.mcount};
      `RBPS_OFF_PCT:     rdmux = 32'(s_r.pct);
      `RBPS_OFF_PRECNT:  rdmux = 32'(rsv);
      `RBPS_OFF_FILLED:  rdmux = 32'(s_r.filled);
      `RBPS_OFF_STATUS:  rdmux = 32'(s_r.status);
      `RBPS_OFF_MASK:    rdmux = 32'(s_r.mask);
      `RBPS_OFF_ERRCODE: rdmux = 32'(s_r.errcode);
      `RBPS_OFF_RDADDR:  rdmux = 32'(s_r.raddr);
      `RBPS_OFF_RDDATA:  rdmux = 32'(mem.rdata);
      default:           rdmux = '0;
    endcase
  end

  assign wv = (rdmux & ~bmask) | (wb_dat_i & bmask);

  always_comb begin
    logic [`RBPS_ST_W-1:0] set;
    logic [`RBPS_ST_W-1:0] clr;
    logic                  chk_clamp;
    set       = '0;
    clr       = '0;
    chk_clamp = 1'b0;
    s_nxt     = s_r;
    s_nxt.ack = req;
    if (req && !wb_we_i) begin
      s_nxt.rdat = rdmux;
    end

    // store sequencing
    unique case (s_r.st)
      ST_IDLE, ST_DONE: begin
      end
      ST_FILL: begin
        if (rdg_valid) begin
          s_nxt.wptr   = s_r.wptr + 1'b1;
          s_nxt.filled = s_r.filled + 1'b1;
          if (s_r.filled + 1'b1 == s_r.size) begin
            s_nxt.st = ST_DONE;
            set[`RBPS_ST_FULL] = 1'b1;
          end
        end
      end
      ST_PRE: begin
        // early portion is a ring; readout order after wrap is not restored
        if (rdg_valid && pre_wr) begin
          s_nxt.wptr = (s_r.wptr + 1'b1 == rsv) ? '0 : s_r.wptr + 1'b1;
          if (s_r.filled < rsv) begin
            s_nxt.filled = s_r.filled + 1'b1;
          end
        end
        if (trig_evt) begin
          set[`RBPS_ST_TRIG] = 1'b1;
          s_nxt.wptr = rsv;
          if (rsv >= s_r.size) begin
            s_nxt.st = ST_DONE;
            set[`RBPS_ST_FULL] = 1'b1;
          end else begin
            s_nxt.st = ST_POST;
          end
        end
      end
      ST_POST: begin
        if (rdg_valid) begin
          s_nxt.wptr   = s_r.wptr + 1'b1;
          s_nxt.filled = s_r.filled + 1'b1;
          if (s_r.wptr + 1'b1 >= s_r.size) begin
            s_nxt.st = ST_DONE;
            set[`RBPS_ST_FULL] = 1'b1;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // register writes
    if (wr_req) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        `RBPS_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            if (wv[`RBPS_CTRL_AUTO] && !s_r.auto_en) begin
              if (s_r.minf) begin
                set[`RBPS_ST_AUTO_REF] = 1'b1;
                s_nxt.errcode = `RBPS_ERR_AUTO_INF;
              end else begin
                s_nxt.auto_en = 1'b1;
                chk_clamp = 1'b1;
              end
            end else if (!wv[`RBPS_CTRL_AUTO]) begin
              s_nxt.auto_en = 1'b0;
            end
            s_nxt.early_mode = wv[`RBPS_CTRL_EARLY];
            if (wv[`RBPS_CTRL_ABORT]) begin
              s_nxt.st = ST_IDLE;
            end else if (wv[`RBPS_CTRL_START]) begin
              s_nxt.wptr   = '0;
              s_nxt.filled = '0;
              s_nxt.st     = wv[`RBPS_CTRL_EARLY] ? ST_PRE : ST_FILL;
            end
          end
        end
        `RBPS_OFF_SIZE: begin
          if (wv >= 32'h0000_0001 && wv <= MAX32) begin
            s_nxt.size    = wv[SZ_W-1:0];
            s_nxt.auto_en = 1'b0;
          end else begin
            set[`RBPS_ST_PARAM] = 1'b1;
            s_nxt.errcode = `RBPS_ERR_PARAM;
          end
        end
        `RBPS_OFF_MCOUNT: begin
          s_nxt.mcount = wv[30:0];
          s_nxt.minf   = wv[`RBPS_MCOUNT_INF];
          chk_clamp    = 1'b1;
        end
        `RBPS_OFF_PCT: begin
          if (wv <= 32'(`RBPS_PCT_FULL)) begin
            s_nxt.pct      = wv[6:0];
            s_nxt.by_count = 1'b0;
          end else begin
            set[`RBPS_ST_PARAM] = 1'b1;
            s_nxt.errcode = `RBPS_ERR_PARAM;
          end
        end
        `RBPS_OFF_PRECNT: begin
          if (wv <= 32'(s_r.size)) begin
            s_nxt.precnt   = wv[SZ_W-1:0];
            s_nxt.by_count = 1'b1;
          end else begin
            set[`RBPS_ST_PARAM] = 1'b1;
            s_nxt.errcode = `RBPS_ERR_PARAM;
          end
        end
        `RBPS_OFF_STATUS: begin
          // only ones in selected lanes clear; merged lanes would read back
          // as ones and wipe flags that were never addressed
          clr = wb_dat_i[`RBPS_ST_W-1:0] & bmask[`RBPS_ST_W-1:0];
        end
        `RBPS_OFF_MASK:   s_nxt.mask = wv[`RBPS_ST_W-1:0];
        `RBPS_OFF_RDADDR: s_nxt.raddr = wv[AW-1:0];
        default: begin
        end
      endcase
    end

    // size follows the measurement count while self-sizing is on
    if (s_nxt.auto_en && !s_nxt.minf) begin
      if (s_nxt.mcount > MAX31) begin
        s_nxt.size = SZ_W'(MAX_BUFFER_SIZE_COMMAND);
        if (chk_clamp) begin
          set[`RBPS_ST_CLAMP] = 1'b1;
          s_nxt.errcode = `RBPS_ERR_CLAMP;
        end
      end else if (s_nxt.mcount != '0) begin
        s_nxt.size = s_nxt.mcount[SZ_W-1:0];
      end
    end

    // a flag raised in the clearing cycle survives
    s_nxt.status = (s_r.status & ~clr) | set;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
    s_nxt.busy   = (s_nxt.st == ST_FILL) || (s_nxt.st == ST_PRE) || (s_nxt.st == ST_POST);
    s_nxt.full   = (s_nxt.st == ST_DONE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.size     <= SZ_W'(`RBPS_RST_SIZE);
      s_r.pct      <= `RBPS_RST_PCT;
      s_r.precnt   <= SZ_W'(`RBPS_RST_PRECNT);
      s_r.mcount   <= `RBPS_RST_MCOUNT;
      s_r.st       <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign irq      = s_r.irq;
  assign storing  = s_r.busy;
  assign buf_full = s_r.full;
endmodule

// ==== test/rbps_top_properties.sv ====
/* Port-level checks of rbps_top, attached by bind.
   Assumes synchronous active-low reset and a one-cycle registered ack. */
`timescale 1ns/1ps
module rbps_top_properties #(
  parameter int MAX_BUFFER_SIZE_COMMAND = 1024,
  parameter int DATA_W     = 32
)(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              rdg_valid,
  input wire logic [DATA_W-1:0] rdg_data,
  input wire logic              trig_evt,
  input wire logic              irq,
  input wire logic              storing,
  input wire logic              buf_full
);
  logic       bus_wr;
  logic       rd_take;
  logic [3:0] wr_age_r;
  logic [3:0] ev_age_r;
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i;
  assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // saturating ages: a cause older than 15 cycles excuses nothing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_age_r <= 4'hF;
      ev_age_r <= 4'hF;
    end else begin
      wr_age_r <= bus_wr ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hF};
      ev_age_r <= (bus_wr || rdg_valid || trig_evt) ? 4'h0 : ev_age_r + {3'h0, ev_age_r != 4'hF};
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_ack_follows;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hold;
    $past(rst_n) && !$past(rd_take) |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_excl;
    !(storing && buf_full);
  endproperty
  a_excl: assert property (p_excl) else $error("storing while full");
  property p_full_hold;
    buf_full && !bus_wr |=> buf_full;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full dropped");
  property p_full_cause;
    $rose(buf_full) |-> ev_age_r <= 4'h3;
  endproperty
  a_full_cause: assert property (p_full_cause) else $error("full without cause");
  property p_store_start;
    $rose(storing) |-> wr_age_r <= 4'h2;
  endproperty
  a_store_start: assert property (p_store_start) else $error("store without start");
  property p_irq_fall;
    $fell(irq) && $past(rst_n) |-> wr_age_r <= 4'h2;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
endmodule

bind rbps_top rbps_top_properties #(.MAX_BUFFER_SIZE_COMMAND(MAX_BUFFER_SIZE_COMMAND), .DATA_W(DATA_W)) i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rdg_valid(rdg_valid),
  .rdg_data(rdg_data), .trig_evt(trig_evt), .irq(irq), .storing(storing),
  .buf_full(buf_full));

// ==== test/rbps_host.sv ====
/* Host model: a classic Wishbone master issuing single cycles.
   Assumes the slave acks; waits for ack with no limit of its own. */
`timescale 1ns/1ps
module rbps_host (
  input  wire logic        clk_sys,
  output      logic        cyc,
  output      logic        stb,
  output      logic        we,
  output      logic [7:0]  adr,
  output      logic [3:0]  sel,
  output      logic [31:0] dat,
  input  wire logic        ack,
  input  wire logic [31:0] dat_i
);
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    q = 'x;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    // only the bench watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    q = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
endmodule

// ==== test/rbps_top_test.sv ====
/* Self-checking bench of rbps_top: sizing, self-sizing, fill, early capture.
   Assumes rbps_host as bus master and the properties file bound in. */
`timescale 1ns/1ps
`include "rbps_defs.svh"
module rbps_top_test;
  localparam int MAXP = 128;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc, stb, we, ack, irq, storing, buf_full;
  logic        rdg_valid = 1'b0;
  logic        trig_evt = 1'b0;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, q;
  logic [31:0] rdg_data = '0;
  logic [31:0] wd[$];
  int          bad_count = 0;
  int          check_count = 0;
  int          s, p;
  always #50 clk_sys = ~clk_sys;
  rbps_top #(.MAX_BUFFER_SIZE_COMMAND(MAXP), .DATA_W(32)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .rdg_valid(rdg_valid), .rdg_data(rdg_data), .trig_evt(trig_evt), .irq(irq),
    .storing(storing), .buf_full(buf_full));
  rbps_host i_host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(dw), .ack(ack), .dat_i(dr));
  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // flags are looked at mid-cycle, clear of the edge that moves them
  task automatic chk1(input string nm, input logic e, ref logic g);
    @(negedge clk_sys);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, '0, q);
    chk32(nm, e, q);
  endtask
  task automatic feed(input int n);
    logic [31:0] v;
    repeat (n) begin
      @(posedge clk_sys);
      v = $urandom;
      wd.push_back(v);
      rdg_valid <= 1'b1;
      rdg_data  <= v;
    end
    @(posedge clk_sys);
    rdg_valid <= 1'b0;
  endtask
  // reserved early locations: size times percent over one hundred, floored
  function automatic logic [31:0] exp_rsv(input int sz, input int pc);
    return 32'(sz * pc / 100);
  endfunction
  // self-sized buffer: the count, clamped to capacity
  function automatic logic [31:0] exp_size(input int mc);
    return (mc > MAXP) ? 32'(MAXP) : 32'(mc);
  endfunction
  initial begin
    #2_000_000;
    bad_count++;
    close_out();
  end
  initial begin
    q = $urandom(49595);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("size", `RBPS_OFF_SIZE, 32'h64);
    rchk("pct", `RBPS_OFF_PCT, 32'h32);
    rchk("rsv", `RBPS_OFF_PRECNT, exp_rsv(100, 50));
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h0);
    rchk("filled", `RBPS_OFF_FILLED, 32'h0);
    rchk("unmapped", 8'hF0, 32'h0);
    wr(`RBPS_OFF_SIZE, 32'h0);
    wr(`RBPS_OFF_SIZE, MAXP + 1);
    rchk("size", `RBPS_OFF_SIZE, 32'h64);
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? 1 : (i == 1) ? MAXP : 1 + $urandom % MAXP;
      wr(`RBPS_OFF_SIZE, s);
      rchk("size", `RBPS_OFF_SIZE, s);
    end
    for (int i = 0; i < 2; i++) begin
      p = 1 + $urandom % MAXP;
      wr(`RBPS_OFF_MCOUNT, p);
      wr(`RBPS_OFF_CTRL, 32'h1);
      rchk("size", `RBPS_OFF_SIZE, exp_size(p));
    end
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h1);
    wr(`RBPS_OFF_MCOUNT, MAXP + 50);
    rchk("size", `RBPS_OFF_SIZE, exp_size(MAXP + 50));
    rchk("err", `RBPS_OFF_ERRCODE, 32'h13A);
    chk1("irq", 1'b0, irq);
    wr(`RBPS_OFF_MASK, 32'h1);
    chk1("irq", 1'b1, irq);
    wr(`RBPS_OFF_STATUS, 32'h1);
    chk1("irq", 1'b0, irq);
    wr(`RBPS_OFF_CTRL, 32'h0);
    wr(`RBPS_OFF_MCOUNT, 32'h7);
    rchk("size", `RBPS_OFF_SIZE, MAXP);
    wr(`RBPS_OFF_CTRL, 32'h1);
    wr(`RBPS_OFF_SIZE, 32'h9);
    rchk("size", `RBPS_OFF_SIZE, 32'h9);
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h0);
    wr(`RBPS_OFF_MCOUNT, 32'h8000_0005);
    wr(`RBPS_OFF_CTRL, 32'h1);
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h0);
    rchk("err", `RBPS_OFF_ERRCODE, 32'h101);
    s = 3 + $urandom % 20;
    wr(`RBPS_OFF_SIZE, s);
    wr(`RBPS_OFF_CTRL, 32'h4);
    chk1("storing", 1'b1, storing);
    feed(s - 1);
    rchk("filled", `RBPS_OFF_FILLED, s - 1);
    chk1("full", 1'b0, buf_full);
    feed(1);
    @(posedge clk_sys);
    chk1("full", 1'b1, buf_full);
    chk1("storing", 1'b0, storing);
    wr(`RBPS_OFF_RDADDR, 32'h0);
    rchk("word", `RBPS_OFF_RDDATA, wd[0]);
    wr(`RBPS_OFF_SIZE, 32'h14);
    for (int i = 0; i < 4; i++) begin
      p = (i < 3) ? i * 50 : $urandom % 101;
      wr(`RBPS_OFF_PCT, p);
      rchk("rsv", `RBPS_OFF_PRECNT, exp_rsv(20, p));
    end
    wr(`RBPS_OFF_PCT, 32'h19);
    wr(`RBPS_OFF_PCT, 32'h65);
    rchk("pct", `RBPS_OFF_PCT, 32'h19);
    wr(`RBPS_OFF_PRECNT, 32'h15);
    rchk("rsv", `RBPS_OFF_PRECNT, exp_rsv(20, 25));
    rchk("err", `RBPS_OFF_ERRCODE, 32'h102);
    wd.delete();
    wr(`RBPS_OFF_CTRL, 32'h6);
    feed(8);
    rchk("filled", `RBPS_OFF_FILLED, exp_rsv(20, 25));
    @(posedge clk_sys);
    trig_evt <= 1'b1;
    @(posedge clk_sys);
    trig_evt <= 1'b0;
    feed(14);
    chk1("full", 1'b0, buf_full);
    feed(1);
    @(posedge clk_sys);
    chk1("full", 1'b1, buf_full);
    chk1("storing", 1'b0, storing);
    feed(3);
    rchk("filled", `RBPS_OFF_FILLED, 32'h14);
    wr(`RBPS_OFF_RDADDR, 32'h5);
    rchk("word", `RBPS_OFF_RDDATA, wd[8]);
    // exact-count split, then an abort out of the early phase
    wr(`RBPS_OFF_PRECNT, 32'h7);
    rchk("rsv", `RBPS_OFF_PRECNT, 32'h7);
    wr(`RBPS_OFF_CTRL, 32'h6);
    chk1("storing", 1'b1, storing);
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h22);
    wr(`RBPS_OFF_CTRL, 32'h8);
    chk1("storing", 1'b0, storing);
    rchk("ctrl", `RBPS_OFF_CTRL, 32'h0);
    close_out();
  end
endmodule
